//--- hw/wwdt_pkg.sv
package wwdt_pkg;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] CFG_OFFSET = 8'h00;
  localparam logic [7:0] RCTL_OFFSET = 8'h04;
  localparam logic [7:0] CMD_OFFSET = 8'h08;
  localparam logic [7:0] STATUS_OFFSET = 8'h0C;
  localparam logic [7:0] MASK_OFFSET = 8'h10;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  // wd_config_word
  localparam int CFG_POST_LSB = 0;
  localparam int CFG_POST_W = 4;
  localparam int CFG_PRE_BIT = 4;
  localparam int CFG_WINOFF_BIT = 6;
  localparam int CFG_HWEN_BIT = 7;
  // reset_control_reg
  localparam int RCTL_IDLE_BIT = 2;
  localparam int RCTL_SLEEP_BIT = 3;
  localparam int RCTL_TMO_BIT = 4;
  localparam int RCTL_SWEN_BIT = 5;
  // Command strobes
  localparam int CMD_CLEAR_BIT = 0;
  localparam int CMD_SLEEP_BIT = 1;
  localparam int CMD_IDLE_BIT = 2;
  // Interrupt status and mask
  localparam int EVT_W = 3;
  localparam int EVT_TIMEOUT_BIT = 0;
  localparam int EVT_EARLY_BIT = 1;
  localparam int EVT_WAKE_BIT = 2;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] CFG_RESET = 8'h5F;
  localparam logic [7:0] RCTL_RESET = 8'h00;
  localparam logic [EVT_W-1:0] STATUS_RESET = 3'h0;
  localparam logic [EVT_W-1:0] MASK_RESET = 3'h0;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int HCLK_PERIOD_NS = 4;
  localparam int OSC_PERIOD_NS = 31250;
  localparam int OSC_DIV_CYC = OSC_PERIOD_NS / HCLK_PERIOD_NS;
  localparam int PRE_DIV_SHORT = 32;
  localparam int PRE_DIV_LONG = 128;
  localparam int CNT_W = 23;

  // Power-save state
  typedef enum logic [1:0] {
    WWDT_RUN,
    WWDT_SLEEP,
    WWDT_IDLE
  } wwdt_mode_t;

endpackage : wwdt_pkg

//--- hw/wwdt_low_power_rc_osc_div.sv
`timescale 1ns/1ns

// Stand-in for the low-power RC oscillator: one tick per oscillator period
module wwdt_osc_div #(
  parameter int DIV = 7812
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Control
  input wire logic enable,
  // Tick out
  output logic tick
);

  logic [15:0] count;

  // ----------------------------------------------------------------
  // Divider
  // ----------------------------------------------------------------
  // Counts while running, restarts when stopped
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      count <= 16'h0000;
      tick <= 1'b0;
    end
    else if (!enable)
    begin
      count <= 16'h0000;
      tick <= 1'b0;
    end
    else if (count == 16'(DIV - 1))
    begin
      count <= 16'h0000;
      tick <= 1'b1;
    end
    else
    begin
      count <= count + 16'h0001;
      tick <= 1'b0;
    end
  end

endmodule : wwdt_osc_div

//--- hw/wwdt_top.sv
// Chosen here: the placing of the registers and the AHB-Lite register port.
`timescale 1ns/1ns

// Function
// - Watchdog counts low-power RC ticks; enabling the watchdog starts that oscillator.
// - Prescaler divides oscillator ticks by 32 or by 128.
// - Base period is 1 ms at divide-by-32, 4 ms at divide-by-128.
// - Four-bit postscale code in config low bits picks one of 16 ratios.
// - Counters clear on device reset and on any completed clock switch.
// - Counters clear on power-save entry, power-save exit and the clear command.
// - Enabled watchdog runs in sleep and idle; time-out there wakes the core.
// - Sleep and idle flags stay set after wake until software clears them.
// - Hardware enable bit set keeps the watchdog always running.
// - Hardware enable clear: watchdog runs only while software enable bit 5 set.
// - Software enable bit clears on every device reset.
// - Window mode: clear before the last quarter of the period causes a reset.
// - Time-out sets flag bit 4, which stays until software clears it.
// - Prescale select 1 means divide-by-128, 0 means divide-by-32.
// - With hardware enable set, clearing software enable changes nothing.
module wwdt_top #(
  parameter int OSC_DIV_CYC = wwdt_pkg::OSC_DIV_CYC
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Core events
  input wire logic clk_switch_done,
  input wire logic wake_in,
  // Core requests
  output logic wd_reset_req,
  output logic wake_req,
  output logic low_power_rc_osc,
  output logic irq
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [7:0] wd_config_word;
  logic wd_sw_enable;
  logic wd_timeout_flag;
  logic sleep_flag;
  logic idle_flag;
  logic [wwdt_pkg::EVT_W-1:0] int_status;
  logic [wwdt_pkg::EVT_W-1:0] int_mask;
  wwdt_pkg::wwdt_mode_t mode;
  logic [wwdt_pkg::CNT_W-1:0] elapsed;
  logic [wwdt_pkg::CNT_W-1:0] period;
  logic [wwdt_pkg::CNT_W-1:0] window_open;
  logic [7:0] dp_addr;
  logic dp_write;
  logic osc_tick;
  logic wd_running;
  logic [3:0] wd_postscale_code;
  logic wd_prescale_select;
  logic wd_window_disable;
  logic wd_hw_enable;
  logic addr_valid;
  logic rd_status;
  logic wr_cfg;
  logic wr_rctl;
  logic wr_cmd;
  logic wr_mask;
  logic wd_clear_instr;
  logic enter_sleep;
  logic enter_idle;
  logic power_save_instr;
  logic timeout;
  logic early_clear;
  logic exit_save;
  logic counter_clear;
  logic [wwdt_pkg::EVT_W-1:0] events;
  logic [31:0] next_rdata;

  // ----------------------------------------------------------------
  // Configuration fields
  // ----------------------------------------------------------------
  assign wd_postscale_code = wd_config_word[wwdt_pkg::CFG_POST_LSB +: wwdt_pkg::CFG_POST_W];
  assign wd_prescale_select = wd_config_word[wwdt_pkg::CFG_PRE_BIT];
  assign wd_window_disable = wd_config_word[wwdt_pkg::CFG_WINOFF_BIT];
  assign wd_hw_enable = wd_config_word[wwdt_pkg::CFG_HWEN_BIT];

  // Hardware enable overrides the software bit
  assign wd_running = wd_hw_enable | wd_sw_enable;

  // ----------------------------------------------------------------
  // AHB-Lite decode
  // ----------------------------------------------------------------
  // Address phase accepted, no wait states
  assign addr_valid = hsel & htrans[1] & hready;
  assign rd_status = addr_valid & ~hwrite & (haddr[7:0] == wwdt_pkg::STATUS_OFFSET)
                     & (haddr[31:8] == 24'h000000);

  // Data-phase write strobes from the latched address
  assign wr_cfg = dp_write & (dp_addr == wwdt_pkg::CFG_OFFSET);
  assign wr_rctl = dp_write & (dp_addr == wwdt_pkg::RCTL_OFFSET);
  assign wr_cmd = dp_write & (dp_addr == wwdt_pkg::CMD_OFFSET);
  assign wr_mask = dp_write & (dp_addr == wwdt_pkg::MASK_OFFSET);

  // Address phase capture
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      dp_addr <= 8'h00;
      dp_write <= 1'b0;
    end
    else
    begin
      dp_addr <= haddr[7:0];
      dp_write <= addr_valid & hwrite & (haddr[31:8] == 24'h000000);
    end
  end

  // Always ready, always OKAY
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
    else
    begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  // Read mux, unmapped reads as zero
  always_comb
  begin
    next_rdata = 32'h00000000;
    if (haddr[31:8] == 24'h000000)
    begin
      case (haddr[7:0])
        wwdt_pkg::CFG_OFFSET: next_rdata = {24'h000000, wd_config_word};
        wwdt_pkg::RCTL_OFFSET:
        begin
          next_rdata[wwdt_pkg::RCTL_SWEN_BIT] = wd_sw_enable;
          next_rdata[wwdt_pkg::RCTL_TMO_BIT] = wd_timeout_flag;
          next_rdata[wwdt_pkg::RCTL_SLEEP_BIT] = sleep_flag;
          next_rdata[wwdt_pkg::RCTL_IDLE_BIT] = idle_flag;
        end
        wwdt_pkg::STATUS_OFFSET: next_rdata = {29'h00000000, int_status};
        wwdt_pkg::MASK_OFFSET: next_rdata = {29'h00000000, int_mask};
        default: next_rdata = 32'h00000000;
      endcase
    end
  end

  // Read data registered for the data phase
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hrdata <= 32'h00000000;
    else if (addr_valid & ~hwrite)
      hrdata <= next_rdata;
  end

  // ----------------------------------------------------------------
  // Command decode
  // ----------------------------------------------------------------
  assign wd_clear_instr = wr_cmd & hwdata[wwdt_pkg::CMD_CLEAR_BIT] & (mode == wwdt_pkg::WWDT_RUN);
  assign enter_sleep = wr_cmd & hwdata[wwdt_pkg::CMD_SLEEP_BIT] & (mode == wwdt_pkg::WWDT_RUN);
  assign enter_idle = wr_cmd & hwdata[wwdt_pkg::CMD_IDLE_BIT] & ~hwdata[wwdt_pkg::CMD_SLEEP_BIT]
                      & (mode == wwdt_pkg::WWDT_RUN);
  assign power_save_instr = enter_sleep | enter_idle;

  // ----------------------------------------------------------------
  // Period and window
  // ----------------------------------------------------------------
  // Prescale 32 or 128 shifted by the postscale code
  always_comb
  begin
    if (wd_prescale_select)
      period = wwdt_pkg::CNT_W'(wwdt_pkg::PRE_DIV_LONG) << wd_postscale_code;
    else
      period = wwdt_pkg::CNT_W'(wwdt_pkg::PRE_DIV_SHORT) << wd_postscale_code;
  end

  // Last quarter of the period opens the clear window
  assign window_open = period - (period >> 2);

  assign timeout = wd_running & osc_tick & (elapsed == period - 1'b1);
  assign early_clear = wd_running & wd_clear_instr & ~wd_window_disable
                       & (elapsed < window_open);
  assign exit_save = (mode != wwdt_pkg::WWDT_RUN) & (wake_in | timeout);
  assign counter_clear = wd_clear_instr | power_save_instr | exit_save | clk_switch_done
                         | ~wd_running;

  // ----------------------------------------------------------------
  // Oscillator and counter
  // ----------------------------------------------------------------
  // Oscillator runs while the watchdog is enabled
  wwdt_osc_div #(
    .DIV(OSC_DIV_CYC)
  ) u_osc (
    .hclk(hclk),
    .hresetn(hresetn),
    .enable(wd_running),
    .tick(osc_tick)
  );

  // Oscillator running indication
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      low_power_rc_osc <= 1'b0;
    else
      low_power_rc_osc <= wd_running;
  end

  // Prescaler and postscaler as one tick counter
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      elapsed <= '0;
    else if (counter_clear | timeout)
      elapsed <= '0;
    else if (osc_tick)
      elapsed <= elapsed + 1'b1;
  end

  // ----------------------------------------------------------------
  // Power-save state
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      mode <= wwdt_pkg::WWDT_RUN;
    else
    begin
      case (mode)
        wwdt_pkg::WWDT_RUN:
        begin
          if (enter_sleep)
            mode <= wwdt_pkg::WWDT_SLEEP;
          else if (enter_idle)
            mode <= wwdt_pkg::WWDT_IDLE;
        end
        wwdt_pkg::WWDT_SLEEP, wwdt_pkg::WWDT_IDLE:
        begin
          if (exit_save)
            mode <= wwdt_pkg::WWDT_RUN;
        end
        default: mode <= wwdt_pkg::WWDT_RUN;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Configuration word and reset control register
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      wd_config_word <= wwdt_pkg::CFG_RESET;
    else if (wr_cfg)
      wd_config_word <= hwdata[7:0];
  end

  // Software enable, cleared by every reset
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      wd_sw_enable <= wwdt_pkg::RCTL_RESET[wwdt_pkg::RCTL_SWEN_BIT];
    else if (wr_rctl)
      wd_sw_enable <= hwdata[wwdt_pkg::RCTL_SWEN_BIT];
  end

  // Flags: hardware sets, writing zero clears, set wins
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wd_timeout_flag <= wwdt_pkg::RCTL_RESET[wwdt_pkg::RCTL_TMO_BIT];
      sleep_flag <= wwdt_pkg::RCTL_RESET[wwdt_pkg::RCTL_SLEEP_BIT];
      idle_flag <= wwdt_pkg::RCTL_RESET[wwdt_pkg::RCTL_IDLE_BIT];
    end
    else
    begin
      if (timeout)
        wd_timeout_flag <= 1'b1;
      else if (wr_rctl & ~hwdata[wwdt_pkg::RCTL_TMO_BIT])
        wd_timeout_flag <= 1'b0;
      if (enter_sleep)
        sleep_flag <= 1'b1;
      else if (wr_rctl & ~hwdata[wwdt_pkg::RCTL_SLEEP_BIT])
        sleep_flag <= 1'b0;
      if (enter_idle)
        idle_flag <= 1'b1;
      else if (wr_rctl & ~hwdata[wwdt_pkg::RCTL_IDLE_BIT])
        idle_flag <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Reset and wake requests
  // ----------------------------------------------------------------
  // One-cycle pulses to the core
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wd_reset_req <= 1'b0;
      wake_req <= 1'b0;
    end
    else
    begin
      wd_reset_req <= (timeout & (mode == wwdt_pkg::WWDT_RUN)) | early_clear;
      wake_req <= timeout & (mode != wwdt_pkg::WWDT_RUN);
    end
  end

  // ----------------------------------------------------------------
  // Interrupts
  // ----------------------------------------------------------------
  always_comb
  begin
    events = '0;
    events[wwdt_pkg::EVT_TIMEOUT_BIT] = timeout;
    events[wwdt_pkg::EVT_EARLY_BIT] = early_clear;
    events[wwdt_pkg::EVT_WAKE_BIT] = timeout & (mode != wwdt_pkg::WWDT_RUN);
  end

  // Sticky status, read clears, set wins
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      int_status <= wwdt_pkg::STATUS_RESET;
    else if (rd_status)
      int_status <= events;
    else
      int_status <= int_status | events;
  end

  // Mask register
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      int_mask <= wwdt_pkg::MASK_RESET;
    else if (wr_mask)
      int_mask <= hwdata[wwdt_pkg::EVT_W-1:0];
  end

  // Level interrupt
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      irq <= 1'b0;
    else
      irq <= |((int_status | events) & int_mask & ~({wwdt_pkg::EVT_W{rd_status}} & ~events));
  end

endmodule : wwdt_top

//--- verif/wwdt_top_sva.sv
`timescale 1ns/1ns

// Port-level checks for the watchdog top
module wwdt_top_sva (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Bus
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  // Requests
  input wire logic wd_reset_req,
  input wire logic wake_req,
  input wire logic low_power_rc_osc
);
  logic wr_pend;
  logic [31:0] wr_addr;

  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);

  // Remember a write address phase
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend <= 1'b0;
      wr_addr <= 32'h0;
    end
    else if (hready)
    begin
      wr_pend <= hsel && htrans[1] && hwrite;
      wr_addr <= haddr;
    end
  end

  // Data phases that turn the watchdog on
  sequence s_hwen_wr;
    wr_pend && hready && wr_addr == 32'(wwdt_pkg::CFG_OFFSET)
    && hwdata[wwdt_pkg::CFG_HWEN_BIT];
  endsequence
  sequence s_swen_wr;
    wr_pend && hready && wr_addr == 32'(wwdt_pkg::RCTL_OFFSET)
    && hwdata[wwdt_pkg::RCTL_SWEN_BIT];
  endsequence

  property p_ready;
    hreadyout == 1'b1;
  endproperty
  property p_okay;
    hresp == 1'b0;
  endproperty
  property p_rst_pulse;
    wd_reset_req |=> !wd_reset_req;
  endproperty
  property p_wake_pulse;
    wake_req |=> !wake_req;
  endproperty
  property p_excl;
    !(wd_reset_req && wake_req);
  endproperty
  property p_hwen;
    s_hwen_wr |-> ##[1:4] low_power_rc_osc;
  endproperty
  property p_swen;
    s_swen_wr |-> ##[1:4] low_power_rc_osc;
  endproperty
  property p_rst_osc;
    wd_reset_req |-> $past(low_power_rc_osc);
  endproperty
  property p_wake_osc;
    wake_req |-> $past(low_power_rc_osc);
  endproperty

  a_ready: assert property (p_ready) else $error("hreadyout low");
  a_okay: assert property (p_okay) else $error("hresp not okay");
  a_rst_pulse: assert property (p_rst_pulse) else $error("reset request too long");
  a_wake_pulse: assert property (p_wake_pulse) else $error("wake too long");
  a_excl: assert property (p_excl) else $error("reset and wake together");
  a_hwen: assert property (p_hwen) else $error("hw enable ignored");
  a_swen: assert property (p_swen) else $error("sw enable ignored");
  a_rst_osc: assert property (p_rst_osc) else $error("reset without osc");
  a_wake_osc: assert property (p_wake_osc) else $error("wake without osc");
endmodule : wwdt_top_sva

bind wwdt_top wwdt_top_sva u_sva (
  .hclk(hclk),
  .hresetn(hresetn),
  .hsel(hsel),
  .haddr(haddr),
  .htrans(htrans),
  .hwrite(hwrite),
  .hwdata(hwdata),
  .hready(hready),
  .hreadyout(hreadyout),
  .hresp(hresp),
  .wd_reset_req(wd_reset_req),
  .wake_req(wake_req),
  .low_power_rc_osc(low_power_rc_osc)
);

//--- verif/tb_windowed_watchdog_timer.sv
`timescale 1ns/1ns

module tb_windowed_watchdog_timer;
  localparam int DIV = 4;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic clk_switch_done, wake_in, wd_reset_req, wake_req, low_power_rc_osc, irq;
  int error_cnt = 0;
  int checked = 0;
  int cyc = 0;
  int n;
  logic [7:0] ra[5];
  logic [31:0] rv[5];
  logic [7:0] cf[4];
  int ex[4];

  wwdt_top #(.OSC_DIV_CYC(DIV)) u_dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .clk_switch_done(clk_switch_done), .wake_in(wake_in), .wd_reset_req(wd_reset_req),
    .wake_req(wake_req), .low_power_rc_osc(low_power_rc_osc), .irq(irq)
  );

  // Clock
  initial
  begin
    hclk = 1'b0;
    forever #2 hclk = ~hclk;
  end

  task automatic summarize;
    $display("errors %0d checks %0d", error_cnt, checked);
    if (error_cnt == 0 && checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : summarize

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("BAD %s exp %h got %h", nm, exp, got);
    end
  endtask : chk

  // One bus transfer: address phase, then data phase
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr <= {24'h0, a};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask : xfer

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    xfer(1'b1, a, d, r);
  endtask : wr

  task automatic rdck(input string nm, input logic [7:0] a, input logic [31:0] m,
                      input logic [31:0] exp);
    logic [31:0] r;
    xfer(1'b0, a, 32'h0, r);
    chk(nm, exp, r & m);
  endtask : rdck

  task automatic do_reset;
    hresetn <= 1'b0;
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
  endtask : do_reset

  // Cycles until the next reset or wake request
  task automatic measure(output int c);
    c = 0;
    while (wd_reset_req !== 1'b1 && wake_req !== 1'b1 && c < 9000)
    begin
      @(posedge hclk);
      c++;
    end
    if (c >= 9000)
    begin
      error_cnt++;
      $display("BAD measure exp pulse got none");
    end
  endtask : measure

  task automatic pulse(input int k);
    if (k == 0)
      clk_switch_done <= 1'b1;
    else
      wake_in <= 1'b1;
    @(posedge hclk);
    clk_switch_done <= 1'b0;
    wake_in <= 1'b0;
  endtask : pulse

  // Hang guard
  always @(posedge hclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 40000)
    begin
      error_cnt++;
      summarize();
    end
  end

  initial
  begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'b010;
    hwdata = 32'h0;
    clk_switch_done = 1'b0;
    wake_in = 1'b0;
    ra = '{wwdt_pkg::CFG_OFFSET, wwdt_pkg::RCTL_OFFSET, wwdt_pkg::STATUS_OFFSET,
           wwdt_pkg::MASK_OFFSET, 8'h20};
    rv = '{32'h5F, 32'h0, 32'h0, 32'h0, 32'h0};
    cf = '{8'hC0, 8'hD0, 8'hC1, 8'hD2};
    ex = '{32 * DIV, 128 * DIV, 64 * DIV, 512 * DIV};
    do_reset();
    // Reset values, unmapped write ignored
    wr(8'h20, 32'hFFFF_FFFF);
    foreach (ra[i]) rdck("reset value", ra[i], 32'hFFFF_FFFF, rv[i]);
    chk("osc off", 1'b0, low_power_rc_osc);
    // Software enable
    wr(wwdt_pkg::RCTL_OFFSET, 32'h20);
    repeat (4) @(posedge hclk);
    chk("osc sw on", 1'b1, low_power_rc_osc);
    wr(wwdt_pkg::RCTL_OFFSET, 32'h0);
    repeat (4) @(posedge hclk);
    chk("osc sw off", 1'b0, low_power_rc_osc);
    wr(wwdt_pkg::RCTL_OFFSET, 32'h20);
    do_reset();
    rdck("sw enable", wwdt_pkg::RCTL_OFFSET, 32'h20, 32'h0);
    // Periods for prescale and postscale settings
    foreach (cf[i])
    begin
      do_reset();
      wr(wwdt_pkg::CFG_OFFSET, {24'h0, cf[i]});
      measure(n);
      chk("period ok", 1'b1, 32'(n >= ex[i] - 8 && n <= ex[i] + 16));
      chk("reset req", 1'b1, wd_reset_req);
    end
    rdck("timeout flag", wwdt_pkg::RCTL_OFFSET, 32'h10, 32'h10);
    rdck("flag held", wwdt_pkg::RCTL_OFFSET, 32'h10, 32'h10);
    chk("irq masked", 1'b0, irq);
    wr(wwdt_pkg::RCTL_OFFSET, 32'h0);
    rdck("flag cleared", wwdt_pkg::RCTL_OFFSET, 32'h10, 32'h0);
    chk("osc stays", 1'b1, low_power_rc_osc);
    // Counter clears by clock switch and by an early clear with the window off
    for (int k = 0; k < 2; k++)
    begin
      do_reset();
      wr(wwdt_pkg::CFG_OFFSET, 32'hC0);
      repeat (40) @(posedge hclk);
      if (k == 0)
        pulse(0);
      else
        wr(wwdt_pkg::CMD_OFFSET, 32'h1);
      measure(n);
      chk("restart", 1'b1, 32'(n >= 32 * DIV - 16 && n <= 32 * DIV + 16));
    end
    // Window mode: early clear, then clear inside the window
    do_reset();
    wr(wwdt_pkg::CFG_OFFSET, 32'h80);
    repeat (20) @(posedge hclk);
    wr(wwdt_pkg::CMD_OFFSET, 32'h1);
    measure(n);
    chk("early reset", 1'b1, 32'(n <= 8 && wd_reset_req === 1'b1));
    rdck("early evt", wwdt_pkg::STATUS_OFFSET, 32'h2, 32'h2);
    do_reset();
    wr(wwdt_pkg::CFG_OFFSET, 32'h80);
    repeat (110) @(posedge hclk);
    wr(wwdt_pkg::CMD_OFFSET, 32'h1);
    measure(n);
    chk("late clear", 1'b1, 32'(n >= 32 * DIV - 16 && n <= 32 * DIV + 16));
    // Sleep: time-out wakes, flags stay, interrupt
    do_reset();
    wr(wwdt_pkg::MASK_OFFSET, 32'h4);
    wr(wwdt_pkg::CFG_OFFSET, 32'hC0);
    wr(wwdt_pkg::CMD_OFFSET, 32'h2);
    measure(n);
    chk("wake", 1'b1, 32'(wake_req === 1'b1 && wd_reset_req === 1'b0));
    repeat (3) @(posedge hclk);
    chk("irq set", 1'b1, irq);
    rdck("sleep flag", wwdt_pkg::RCTL_OFFSET, 32'h8, 32'h8);
    rdck("wake evt", wwdt_pkg::STATUS_OFFSET, 32'h4, 32'h4);
    repeat (2) @(posedge hclk);
    chk("irq clear", 1'b0, irq);
    wr(wwdt_pkg::RCTL_OFFSET, 32'h0);
    rdck("sleep clr", wwdt_pkg::RCTL_OFFSET, 32'h8, 32'h0);
    // Idle left by another wake source, which also restarts the count
    wr(wwdt_pkg::CMD_OFFSET, 32'h4);
    repeat (20) @(posedge hclk);
    pulse(1);
    repeat (2) @(posedge hclk);
    rdck("idle flag", wwdt_pkg::RCTL_OFFSET, 32'h4, 32'h4);
    measure(n);
    chk("idle exit", 1'b1, 32'(wd_reset_req === 1'b1 && n >= 32 * DIV - 16));
    summarize();
  end
endmodule : tb_windowed_watchdog_timer
